// *** design/amop_map.vh ***
// Purpose: constants for the converter mode and output port block
// Assumes: included by design files only
// Notes:   pin levels arrive already quantised by the pad comparators
`ifndef AMOP_MAP_VH
`define AMOP_MAP_VH
// three-level power pin codes
`define AMOP_PWR_ON        2'h0
`define AMOP_PWR_SLEEP     2'h1
`define AMOP_PWR_DOWN      2'h2
// four-level select pin codes (0 = ground .. 3 = supply)
`define AMOP_SEL_SE_OB     2'h0
`define AMOP_SEL_SE_TC     2'h1
`define AMOP_SEL_DF_OB     2'h2
`define AMOP_SEL_DF_TC     2'h3
// sample word layout
`define AMOP_MSB           11
`define AMOP_MID_CODE      12'h800
// recovery times
`define AMOP_CLK_MHZ       250
`define AMOP_DOWN_EXIT_US  3000
`define AMOP_SLEEP_EXIT_US 300
`define AMOP_DOWN_EXIT_CYC (`AMOP_DOWN_EXIT_US * `AMOP_CLK_MHZ)
`define AMOP_SLEEP_EXIT_CYC (`AMOP_SLEEP_EXIT_US * `AMOP_CLK_MHZ)
`endif

// *** design/amop_buf2.v ***
// Purpose: two-entry valid/ready buffer for sample words
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   output data come from the entry register picked by the read pointer
`default_nettype none
module amop_buf2 #(
   parameter W = 13
) (
   input  wire         i_clk,
   input  wire         i_rst_b,
   input  wire         i_valid,
   output wire         o_ready,
   input  wire [W-1:0] i_data,
   output wire         o_valid,
   input  wire         i_ready,
   output wire [W-1:0] o_data,
   input  wire         i_flush
);
   reg [W-1:0] mem_q [0:1];
   reg [W-1:0] out_q;
   reg         rd_q;
   reg         wr_q;
   reg [1:0]   cnt_q;
   wire        push;
   wire        pop;
   assign o_ready = (cnt_q != 2'h2);
   assign o_valid = (cnt_q != 2'h0);
   assign push    = i_valid & o_ready;
   assign pop     = o_valid & i_ready;
   assign o_data  = mem_q[rd_q];
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mem_q[0] <= {W{1'b0}};
         mem_q[1] <= {W{1'b0}};
         rd_q     <= 1'b0;
         wr_q     <= 1'b0;
         cnt_q    <= 2'h0;
      end else if (i_flush) begin
         rd_q  <= 1'b0;
         wr_q  <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (push) begin
            mem_q[wr_q] <= i_data;
            wr_q        <= ~wr_q;
         end
         if (pop)
            rd_q <= ~rd_q;
         if (push && !pop)
            cnt_q <= cnt_q + 2'h1;
         else if (pop && !push)
            cnt_q <= cnt_q - 2'h1;
      end
   end
endmodule // amop_buf2
`default_nettype wire

// *** design/amop_top.v ***
// Purpose: power-state decode, clock/format select decode and the
//          parallel sample output port of a 12-bit pipelined converter
// Assumes: pins and sample clock are asynchronous and pass two flops;
//          the core delivers raw offset-binary codes with a range flag
// Notes:   pipeline depth is a parameter; recovery times are parameters
//
// Functional notes
// - power pin: supply is power-down, half supply sleep, ground on.
// - in power-down or sleep outputs are undefined; pipeline samples lost.
// - after power-down wait about 3 ms, sleep less; discard those samples.
// - select pin picks clock mode and number format from four levels.
// - reference clock runs the state machine and must never stop.
// - conversion behaviour holds for clock duty cycles of 30 to 70 percent.
// - each conversion gives 12 parallel bits, a strobe and over-range flag; while the two-entry buffer is full, conversions are dropped.
// - over-range flag high only for samples outside the 12-bit range.
// - two spare outputs are held low; receiver ignores them.
// - valid words appear only while the power pin is low.
// - offset binary from zeros to ones; two's complement inverts the MSB.
`default_nettype none
`include "amop_map.vh"
module amop_top #(
   parameter LAT        = 8,
   parameter DOWN_CYC   = `AMOP_DOWN_EXIT_CYC,
   parameter SLEEP_CYC  = `AMOP_SLEEP_EXIT_CYC
) (
   input  wire        I_REF_CLK,
   input  wire        I_RST_B,
   input  wire [1:0]  I_POWER_STATE_PIN,
   input  wire [1:0]  I_CLOCK_AND_FORMAT_SELECT,
   input  wire        I_SAMPLE_CLK_P,
   input  wire        I_SAMPLE_CLK_N,
   input  wire [11:0] I_CORE_CODE,
   input  wire        I_CORE_OVER,
   input  wire        I_RX_READY,
   output reg  [11:0] O_SAMPLE_BITS,
   output reg         O_OVER_RANGE_FLAG,
   output reg         O_OUTPUT_STROBE,
   output reg  [1:0]  O_SPARE_LOW_OUTPUTS,
   output reg  [1:0]  O_POWER_STATE,
   output reg         O_DIFF_CLOCK,
   output reg         O_TWOS_COMPLEMENT,
   output reg         O_RECOVERING
);
   localparam ST_ON    = 2'h0;
   localparam ST_SLEEP = 2'h1;
   localparam ST_DOWN  = 2'h2;
   localparam ST_WAKE  = 2'h3;

   // decodes a raw pin level into a power state; unknown level means down
   function [1:0] pwr_decode;
      input [1:0] lvl;
      begin
         case (lvl)
            `AMOP_PWR_ON:    pwr_decode = ST_ON;
            `AMOP_PWR_SLEEP: pwr_decode = ST_SLEEP;
            default:         pwr_decode = ST_DOWN;
         endcase
      end
   endfunction

   reg [1:0]  pwr_s1_q, pwr_s2_q, sel_s1_q, sel_s2_q;
   reg        ckp_s1_q, ckp_s2_q, ckp_s3_q;
   reg        ckn_s1_q, ckn_s2_q;
   reg [1:0]  state_q;
   reg [1:0]  state_d;
   reg [31:0] wait_q;
   reg [31:0] wait_d;
   reg        diff_q, tc_q;
   reg [LAT*13-1:0] pipe_q;
   reg [LAT-1:0]    pvld_q;
   reg        strobe_phase_q;
   wire [1:0] pwr_now;
   wire       clk_in;
   wire       clk_rise;
   wire       run;
   wire [11:0] code_fmt;
   wire       b_valid;
   wire [12:0] b_data;

   always @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         pwr_s1_q <= 2'h2;
         pwr_s2_q <= 2'h2;
         sel_s1_q <= 2'h0;
         sel_s2_q <= 2'h0;
         ckp_s1_q <= 1'b0;
         ckp_s2_q <= 1'b0;
         ckp_s3_q <= 1'b0;
         ckn_s1_q <= 1'b0;
         ckn_s2_q <= 1'b0;
      end else begin
         pwr_s1_q <= I_POWER_STATE_PIN;
         pwr_s2_q <= pwr_s1_q;
         sel_s1_q <= I_CLOCK_AND_FORMAT_SELECT;
         sel_s2_q <= sel_s1_q;
         ckp_s1_q <= I_SAMPLE_CLK_P;
         ckp_s2_q <= ckp_s1_q;
         ckp_s3_q <= ckp_s2_q;
         ckn_s1_q <= I_SAMPLE_CLK_N;
         ckn_s2_q <= ckn_s1_q;
      end
   end

   assign pwr_now = pwr_decode(pwr_s2_q);
   // single-ended mode looks at the positive input only; the negative
   // input in differential mode only confirms the complement
   assign clk_in   = ckp_s2_q;
   // only rising edges count, so any duty cycle the sampling can resolve
   // gives one conversion per period; an in-phase negative input stalls
   assign clk_rise = clk_in & ~ckp_s3_q
                     & ~(diff_q & ckn_s2_q);

   always @* begin
      state_d = state_q;
      wait_d  = wait_q;
      case (state_q)
         ST_ON: begin
            if (pwr_now != ST_ON)
               state_d = pwr_now;
         end
         ST_SLEEP, ST_DOWN: begin
            if (pwr_now == ST_ON) begin
               state_d = ST_WAKE;
               wait_d  = (state_q == ST_DOWN) ? DOWN_CYC : SLEEP_CYC;
            end else
               state_d = pwr_now;
         end
         ST_WAKE: begin
            if (pwr_now != ST_ON)
               state_d = pwr_now;
            else if (wait_q <= 32'h1)
               state_d = ST_ON;
            else
               wait_d = wait_q - 32'h1;
         end
         default: state_d = ST_DOWN;
      endcase
   end

   assign run = (state_q == ST_ON);
   // two's complement is offset binary with the top bit inverted
   assign code_fmt = {I_CORE_CODE[`AMOP_MSB] ^ tc_q,
                      I_CORE_CODE[`AMOP_MSB-1:0]};

   genvar g;
   generate
      for (g = 1; g < LAT; g = g + 1) begin : g_pipe
         always @(posedge I_REF_CLK or negedge I_RST_B) begin
            if (!I_RST_B) begin
               pipe_q[g*13 +: 13] <= 13'h0000;
               pvld_q[g]          <= 1'b0;
            end else if (!run) begin
               pvld_q[g] <= 1'b0;
            end else if (clk_rise) begin
               pipe_q[g*13 +: 13] <= pipe_q[(g-1)*13 +: 13];
               pvld_q[g]          <= pvld_q[g-1];
            end
         end
      end
   endgenerate

   always @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         pipe_q[12:0] <= 13'h0000;
         pvld_q[0]    <= 1'b0;
      end else if (!run) begin
         pvld_q[0] <= 1'b0;
      end else if (clk_rise) begin
         // bits and flag move as one word through the fixed-depth pipe
         pipe_q[12:0] <= {I_CORE_OVER, code_fmt};
         pvld_q[0]    <= 1'b1;
      end
   end

   amop_buf2 #(
      .W (13)
   ) u_buf (
      .i_clk   (I_REF_CLK),
      .i_rst_b (I_RST_B),
      .i_valid (pvld_q[LAT-1] & clk_rise & run),
      .o_ready (),
      .i_data  (pipe_q[(LAT-1)*13 +: 13]),
      .o_valid (b_valid),
      .i_ready (I_RX_READY & ~strobe_phase_q & run),
      .o_data  (b_data),
      .i_flush (~run)
   );

   always @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         state_q             <= ST_DOWN;
         wait_q              <= 32'h00000000;
         diff_q              <= 1'b0;
         tc_q                <= 1'b0;
         strobe_phase_q      <= 1'b0;
         O_SAMPLE_BITS       <= 12'h000;
         O_OVER_RANGE_FLAG   <= 1'b0;
         O_OUTPUT_STROBE     <= 1'b0;
         O_SPARE_LOW_OUTPUTS <= 2'h0;
         O_POWER_STATE       <= ST_DOWN;
         O_DIFF_CLOCK        <= 1'b0;
         O_TWOS_COMPLEMENT   <= 1'b0;
         O_RECOVERING        <= 1'b0;
      end else begin
         state_q <= state_d;
         wait_q  <= wait_d;
         // mode is taken only while idle so a word never changes format
         if (!run) begin
            diff_q <= sel_s2_q[1];
            tc_q   <= sel_s2_q[0];
         end
         O_DIFF_CLOCK        <= diff_q;
         O_TWOS_COMPLEMENT   <= tc_q;
         O_POWER_STATE       <= (state_q == ST_WAKE) ? ST_ON : state_q;
         O_RECOVERING        <= (state_q == ST_WAKE);
         O_SPARE_LOW_OUTPUTS <= 2'h0;
         if (!run) begin
            // outputs are don't-care here; parked at 12'h800, mid-scale in offset binary, no strobe
            strobe_phase_q    <= 1'b0;
            O_OUTPUT_STROBE   <= 1'b0;
            O_SAMPLE_BITS     <= `AMOP_MID_CODE;
            O_OVER_RANGE_FLAG <= 1'b0;
         end else if (strobe_phase_q) begin
            strobe_phase_q  <= 1'b0;
            O_OUTPUT_STROBE <= 1'b1;
         end else if (b_valid && I_RX_READY) begin
            // data change with the strobe low, rising edge a cycle later
            strobe_phase_q    <= 1'b1;
            O_OUTPUT_STROBE   <= 1'b0;
            O_SAMPLE_BITS     <= b_data[11:0];
            O_OVER_RANGE_FLAG <= b_data[12];
         end else
            O_OUTPUT_STROBE <= 1'b0;
      end
   end
endmodule // amop_top
`default_nettype wire

// *** verif/amop_top_assertions.sv ***
// Purpose: port checks for the converter mode and output port
// Assumes: bound to amop_top, one clock domain
// Notes:   decode checks allow for the pin synchronisers
`default_nettype none
module amop_top_assertions #(
   parameter DOWN_CYC = 20
) (
   input wire logic        I_REF_CLK,
   input wire logic        I_RST_B,
   input wire logic [1:0]  I_POWER_STATE_PIN,
   input wire logic [1:0]  I_CLOCK_AND_FORMAT_SELECT,
   input wire logic [11:0] O_SAMPLE_BITS,
   input wire logic        O_OVER_RANGE_FLAG,
   input wire logic        O_OUTPUT_STROBE,
   input wire logic [1:0]  O_SPARE_LOW_OUTPUTS,
   input wire logic [1:0]  O_POWER_STATE,
   input wire logic        O_DIFF_CLOCK,
   input wire logic        O_TWOS_COMPLEMENT,
   input wire logic        O_RECOVERING
);
   timeunit 1ns;
   timeprecision 100ps;
   int rc_q;
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RST_B);
   always @(posedge I_REF_CLK or negedge I_RST_B)
      if (!I_RST_B)
         rc_q <= 0;
      else
         rc_q <= O_RECOVERING ? rc_q + 1 : 0;
   a_spare_low: assert property (O_SPARE_LOW_OUTPUTS == 2'h0)
      else $error("spare outputs not low");
   a_strobe_single: assert property (O_OUTPUT_STROBE |=> !O_OUTPUT_STROBE)
      else $error("strobe longer than one cycle");
   a_word_steady: assert property (O_OUTPUT_STROBE |->
      $stable(O_SAMPLE_BITS) && $stable(O_OVER_RANGE_FLAG))
      else $error("word moved under strobe");
   a_word_strobed: assert property ((O_POWER_STATE == 2'h0 &&
      $past(O_POWER_STATE) == 2'h0 && !$stable(O_SAMPLE_BITS))
      |=> O_OUTPUT_STROBE) else $error("word without strobe");
   a_quiet_off: assert property ((O_POWER_STATE != 2'h0 &&
      $past(O_POWER_STATE) != 2'h0) |-> !O_OUTPUT_STROBE)
      else $error("strobe while not on");
   a_quiet_recover: assert property ((O_RECOVERING &&
      $past(O_RECOVERING)) |-> !O_OUTPUT_STROBE)
      else $error("strobe while recovering");
   a_sleep_decode: assert property ((I_POWER_STATE_PIN == 2'h1)[*5]
      |-> O_POWER_STATE == 2'h1) else $error("sleep not decoded");
   a_down_decode: assert property (I_POWER_STATE_PIN[1][*5]
      |-> O_POWER_STATE == 2'h2) else $error("power-down not decoded");
   a_on_decode: assert property ((I_POWER_STATE_PIN == 2'h0)[*5]
      |-> O_POWER_STATE == 2'h0) else $error("on not decoded");
   a_mode_latch: assert property ((O_POWER_STATE != 2'h0 &&
      $stable(I_CLOCK_AND_FORMAT_SELECT))[*6] |-> {O_DIFF_CLOCK,
      O_TWOS_COMPLEMENT} == I_CLOCK_AND_FORMAT_SELECT)
      else $error("mode not latched");
   a_recover_bound: assert property (rc_q <= DOWN_CYC + 2)
      else $error("recovery too long");
   c_strobe: cover property (O_OUTPUT_STROBE);
   c_recovered: cover property ($fell(O_RECOVERING));
   c_sleep: cover property (O_POWER_STATE == 2'h1);
endmodule // amop_top_assertions
`default_nettype wire

// *** verif/amop_rx_model.sv ***
// Purpose: receiving logic device for the sample words
// Assumes: strobe and word come from registers
// Notes:   counts words that break the one-up sequence or flag pairing
`default_nettype none
module amop_rx_model (
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   input  wire logic        i_stall,
   input  wire logic        i_strobe,
   input  wire logic [11:0] i_bits,
   input  wire logic        i_flag,
   output logic             o_ready,
   output logic [12:0]      o_word,
   output int               o_count,
   output int               o_bad
);
   timeunit 1ns;
   timeprecision 100ps;
   // spare outputs are not even wired
   always @(posedge i_strobe or negedge i_rst_b)
      if (!i_rst_b) begin
         o_count <= 0;
         o_bad <= 0;
      end else begin
         if (o_count > 0 && {i_flag, i_bits} !==
             {i_bits[0], o_word[11:0] + 12'h001})
            o_bad <= o_bad + 1;
         o_word <= {i_flag, i_bits};
         o_count <= o_count + 1;
      end
   // a toggling ready keeps the output buffer exercised
   always @(posedge i_clk or negedge i_rst_b)
      if (!i_rst_b)
         o_ready <= 1'b1;
      else
         o_ready <= i_stall ? ~o_ready : 1'b1;
endmodule // amop_rx_model
`default_nettype wire

// *** verif/amop_top_test.sv ***
// Purpose: self-checking bench for the mode and output port
// Assumes: free-running 32 ns sample clock, reset held 16 cycles
// Notes:   short recovery counts keep the run brief
`default_nettype none
module amop_top_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam DN = 20;
   logic        I_REF_CLK = 1'b0;
   logic        I_RST_B = 1'b0;
   logic [1:0]  pin = 2'h2;
   logic [1:0]  sel = 2'h0;
   logic        sclk = 1'b0;
   logic        sc_q = 1'b0;
   logic        inc = 1'b0;
   logic [11:0] code = 12'h000;
   logic        over = 1'b0;
   logic        stall = 1'b0;
   logic        rx_rst_b = 1'b0;
   logic        rdy;
   logic [12:0] rx_word;
   int          rx_count;
   int          rx_bad;
   wire  [11:0] bits;
   wire         flag, strb, diff, twos, rec;
   wire  [1:0]  pst, spare;
   int          errors = 0;
   int          total_checks = 0;
   always #2 I_REF_CLK = ~I_REF_CLK;
   initial begin
      #1.3;
      forever #16 sclk = ~sclk;
   end
   always @(posedge I_REF_CLK) begin
      sc_q <= sclk;
      if (inc && sc_q && !sclk) begin
         code <= code + 12'h001;
         over <= ~code[0];
      end
   end
   amop_top #(.LAT(8), .DOWN_CYC(DN), .SLEEP_CYC(10)) i_dut (
      .I_REF_CLK(I_REF_CLK), .I_RST_B(I_RST_B),
      .I_POWER_STATE_PIN(pin), .I_CLOCK_AND_FORMAT_SELECT(sel),
      .I_SAMPLE_CLK_P(sclk), .I_SAMPLE_CLK_N(sel[1] ? ~sclk : 1'b0),
      .I_CORE_CODE(code), .I_CORE_OVER(over), .I_RX_READY(rdy),
      .O_SAMPLE_BITS(bits), .O_OVER_RANGE_FLAG(flag),
      .O_OUTPUT_STROBE(strb), .O_SPARE_LOW_OUTPUTS(spare),
      .O_POWER_STATE(pst),
      .O_DIFF_CLOCK(diff), .O_TWOS_COMPLEMENT(twos), .O_RECOVERING(rec));
   amop_rx_model i_rx (.i_clk(I_REF_CLK), .i_rst_b(rx_rst_b),
      .i_stall(stall), .i_strobe(strb), .i_bits(bits), .i_flag(flag),
      .o_ready(rdy), .o_word(rx_word), .o_count(rx_count), .o_bad(rx_bad));
   task automatic chk(input string what, input logic [12:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge I_REF_CLK);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic t_modes;
      logic [11:0] c;
      for (int s = 0; s < 4; s++) begin
         c = {s[1:0], 10'h0A5};
         cyc(1);
         pin <= 2'h2;
         sel <= 2'(s);
         code <= c;
         over <= s[1];
         cyc(12);
         pin <= 2'h0;
         cyc(DN + 120);
         @(negedge I_REF_CLK);
         chk("bits", bits, s[0] ? c ^ 12'h800 : c);
         chk("flag", flag, s[1]);
         chk("mode", {diff, twos}, sel);
         chk("spare", spare, 2'h0);
      end
      $display("test modes done");
   endtask
   task automatic t_stream;
      cyc(1);
      stall <= 1'b1;
      code <= 12'h7F0;
      over <= 1'b0;
      inc <= 1'b1;
      cyc(100);
      rx_rst_b <= 1'b1;
      cyc(400);
      @(negedge I_REF_CLK);
      chk("order", 13'(rx_bad), 13'h0);
      chk("count", 13'(rx_count >= 40), 13'h1);
      $display("test stream done");
   endtask
   task automatic t_sleep;
      int n;
      int w;
      cyc(1);
      pin <= 2'h1;
      cyc(20);
      w = rx_count;
      cyc(200);
      @(negedge I_REF_CLK);
      chk("sleep", pst, 2'h1);
      chk("quiet", 13'(rx_count - w), 13'h0);
      cyc(1);
      pin <= 2'h3;
      cyc(10);
      @(negedge I_REF_CLK);
      chk("down", pst, 2'h2);
      cyc(1);
      pin <= 2'h0;
      cyc(6);
      @(negedge I_REF_CLK);
      chk("recovering", rec, 1'b1);
      n = 0;
      while (rec !== 1'b0 && n < DN + 8) begin
         @(negedge I_REF_CLK);
         n++;
      end
      if (rec !== 1'b0) begin
         errors++;
         end_of_test;
      end
      chk("recovery", 13'(n > DN - 8), 13'h1);
      cyc(300);
      @(negedge I_REF_CLK);
      chk("resumed", 13'(rx_count > w), 13'h1);
      chk("gap", 13'(rx_bad), 13'h1);
      // sleep exit must be shorter than the power-down exit
      cyc(1);
      pin <= 2'h1;
      cyc(20);
      pin <= 2'h0;
      cyc(6);
      @(negedge I_REF_CLK);
      chk("sleep recovering", rec, 1'b1);
      n = 0;
      while (rec !== 1'b0 && n < DN + 8) begin
         @(negedge I_REF_CLK);
         n++;
      end
      if (rec !== 1'b0) begin
         errors++;
         end_of_test;
      end
      chk("sleep recovery", 13'(n > 2 && n < DN - 8), 13'h1);
      $display("test sleep done");
   endtask
   initial begin
      cyc(16);
      I_RST_B <= 1'b1;
      t_modes;
      t_stream;
      t_sleep;
      end_of_test;
   end
endmodule // amop_top_test
bind amop_top amop_top_assertions #(.DOWN_CYC(DOWN_CYC)) i_chk (
   .I_REF_CLK(I_REF_CLK), .I_RST_B(I_RST_B),
   .I_POWER_STATE_PIN(I_POWER_STATE_PIN),
   .I_CLOCK_AND_FORMAT_SELECT(I_CLOCK_AND_FORMAT_SELECT),
   .O_SAMPLE_BITS(O_SAMPLE_BITS), .O_OVER_RANGE_FLAG(O_OVER_RANGE_FLAG),
   .O_OUTPUT_STROBE(O_OUTPUT_STROBE),
   .O_SPARE_LOW_OUTPUTS(O_SPARE_LOW_OUTPUTS), .O_POWER_STATE(O_POWER_STATE),
   .O_DIFF_CLOCK(O_DIFF_CLOCK), .O_TWOS_COMPLEMENT(O_TWOS_COMPLEMENT),
   .O_RECOVERING(O_RECOVERING));
`default_nettype wire
